// [record_store_consts.svh]
// constants of the measurement record store: offsets, fields, resets, timing
`ifndef RECORD_STORE_CONSTS_SVH
`define RECORD_STORE_CONSTS_SVH

// ****************************************
// capacities
// ****************************************
`define REC_CAP        9'd400
`define SLOT_MAX       7'd126
`define SLOT_NONE      7'h7f

// ****************************************
// register byte offsets
// ****************************************
`define A_SET          8'h00
`define A_CMD          8'h04
`define A_STAT         8'h08
`define A_CNT          8'h0c
`define A_SLOT         8'h10

// ****************************************
// command bit positions
// ****************************************
`define C_CLR          0
`define C_BULK         1
`define C_STEP         2
`define C_NEXT         3
`define C_TRG          4
`define C_MENU_RST     5
`define C_STD_RST      6
`define C_SYS_RST      7
`define C_SAVE         8
`define C_LOAD         9
`define C_LOCK_SET     10
`define C_LOCK_CLR     11

// ****************************************
// reset values
// ****************************************
`define SET_RST        16'h0058
`define SEL_RST        7'h01

// ****************************************
// timing
// ****************************************
`define CLK_HZ         64'd125000000
`define CAL_PERIOD_MIN 64'd30
`define CAL_TIME_MS    64'd55
`define CAL_PERIOD_CYC (`CAL_PERIOD_MIN * 64'd60 * `CLK_HZ)
`define CAL_TIME_CYC   (`CAL_TIME_MS * `CLK_HZ / 64'd1000)

`endif

// [record_store_pkg.sv]
// types shared by the measurement record store
package record_store_pkg;

	typedef struct packed
	{
		logic [4:0] comp;
		logic [3:0] range;
		logic       autorange;
		logic       gpib;
		logic       slow;
		logic       cal_auto;
		logic       out_en;
		logic       ext;
		logic       store_en;
	} settings_t;

	typedef struct packed
	{
		logic [31:0] res;
		logic [31:0] volt;
	} record_t;

	typedef struct packed
	{
		logic       is_end;
		logic [8:0] index;
		record_t    rec;
	} tx_t;

	typedef struct packed
	{
		logic      has_lock;
		logic      lock;
		settings_t set;
	} slot_t;

	typedef struct packed
	{
		logic        read;
		logic        write;
		logic [7:0]  address;
		logic [31:0] writedata;
	} avs_req_t;

	typedef enum logic [1:0] {D_IDLE, D_BULK, D_STEP, D_WAIT} dump_st_t;

endpackage

// [measurement_record_store.sv]
// measurement record store with panel slots, self-calibration pacing and avalon registers
`timescale 1ns/1ps
`include "record_store_consts.svh"

// ****************************************
// Notes on behaviour
// ****************************************
//
// Notes on behaviour
// - while enabled, each stored result is appended in trigger order, 400 at most
// - external source stores one per trigger; free-run stores first result after trigger
// - key, pin or remote trigger stores one record and blinks the store lamp
// - store is run only by remote commands; enabling it lights the lamp
// - bulk dump sends every record in order, then an end marker
// - step dump sends one record, waits for next character, ends with end marker
// - a full store ignores further triggers and keeps its records
// - records accumulate across triggers and dumps until cleared
// - enable edge, range, comparator, clear, resets and power-up empty the store
// - auto-ranging is unavailable while the store is enabled
// - key lockout blocks every front key except trigger
// - lockout survives power loss
// - 126 non-volatile slots each hold a full settings snapshot
// - saving overwrites a slot; occupied slots are flagged used
// - lockout joins a snapshot only on a remote save
// - loading an empty slot beeps and changes nothing; selector sees used slots
// - auto mode calibrates every 30 minutes; manual mode on falling edge of calibration line
// - slow rate calibrates inside every measurement
// - calibration lasts 55 ms and suspends measurement
// - result output sends one value per key or pin trigger
// - automatic result output only on the serial port
// - pin trigger loads selected slot unless select lines are unchanged
module measurement_record_store
#(
	parameter logic [37:0] CAL_PERIOD_CYC = 38'(`CAL_PERIOD_CYC),
	parameter logic [22:0] CAL_TIME_CYC   = 23'(`CAL_TIME_CYC)
)
(
	input  wire  logic                        clk_sys_in,
	input  wire  logic                        rst_b_in,
	input  wire  record_store_pkg::avs_req_t  avs_req_in,
	output logic                              avs_waitrequest_out,
	output logic [31:0]                       avs_readdata_out,
	input  wire  logic                        meas_done_in,
	input  wire  record_store_pkg::record_t   meas_rec_in,
	output logic                              meas_start_out,
	output logic                              meas_suspend_out,
	input  wire  logic                        front_measure_request_pin_in,
	input  wire  logic [15:0]                 front_keys_in,
	output logic [15:0]                       keys_out,
	input  wire  logic                        front_save_in,
	input  wire  logic                        front_load_in,
	input  wire  logic [6:0]                  front_slot_in,
	output logic                              front_slot_used_out,
	input  wire  logic                        measure_request_pin_b_in,
	input  wire  logic [6:0]                  panel_select_lines_in,
	input  wire  logic                        cal_line_b_in,
	output record_store_pkg::tx_t             tx_out,
	output logic                              tx_valid_out,
	input  wire  logic                        tx_ready_in,
	output record_store_pkg::settings_t       settings_out,
	output logic                              key_lock_out,
	output logic                              autorange_en_out,
	output logic                              store_lamp_out,
	output logic                              beep_out
);
	import record_store_pkg::*;

	typedef struct packed
	{
		dump_st_t    dst;
		logic [8:0]  cnt;
		logic [8:0]  idx;
		logic        armed;
		logic        out_pend;
		logic        meas_pend;
		logic        inflight;
		logic        cal_done;
		settings_t   set;
		logic [6:0]  slot_sel;
		logic [6:0]  last_sel;
		logic        pin_q;
		logic        cal_q;
		logic [22:0] cal_left;
		logic [37:0] cal_tmr;
		tx_t         tx;
		logic        tx_valid;
		logic        blink;
		logic        beep;
		logic        meas_start;
		logic        rd_done;
		logic [31:0] rdata;
	} state_t;

	state_t      q;
	state_t      d;

	// ****************************************
	// non-volatile storage
	// ****************************************
	// slots, used flags and lockout have no reset: they model cells that keep power-off state
	slot_t       slot_mem [0:127];
	logic [127:0] used_q = '0;
	logic        kl_q = 1'b0;
	logic        kl_d;
	record_t     rec_mem [0:399];
	logic        rec_we;
	logic        slot_we;
	logic [6:0]  slot_wa;
	slot_t       slot_wd;

	logic        busy;
	logic        rd;
	logic        wr;
	logic [31:0] cmd;
	logic        measure_request_pin_key;
	logic        measure_request_pin_pin;
	logic        measure_request_pin_rmt;
	logic        load_req;
	logic [6:0]  load_slot;
	logic        load_ok;
	logic        clear;
	logic        any_rst;
	logic        free;
	settings_t   nset;

	assign busy = (q.cal_left != 23'h0);
	assign rd   = avs_req_in.read;
	assign wr   = avs_req_in.write;
	assign cmd  = (wr && avs_req_in.address == `A_CMD) ? avs_req_in.writedata : 32'h0;
	assign free = !q.tx_valid || tx_ready_in;

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		d          = q;
		d.blink    = 1'b0;
		d.beep     = 1'b0;
		d.meas_start = 1'b0;
		d.pin_q    = measure_request_pin_b_in;
		d.cal_q    = cal_line_b_in;
		kl_d       = kl_q;
		rec_we     = 1'b0;
		slot_we    = 1'b0;
		slot_wa    = q.slot_sel;
		slot_wd    = '0;
		load_req   = 1'b0;
		load_slot  = q.slot_sel;

		// triggers: pin and remote only act with the external source
		measure_request_pin_key = front_measure_request_pin_in;
		measure_request_pin_pin = q.set.ext && q.pin_q && !measure_request_pin_b_in;
		measure_request_pin_rmt = q.set.ext && cmd[`C_TRG];

		// lockout
		if (cmd[`C_LOCK_SET])
			kl_d = 1'b1;
		if (cmd[`C_LOCK_CLR])
			kl_d = 1'b0;

		// saves: only a remote save carries the lockout
		if (cmd[`C_SAVE] && q.slot_sel != 7'h0 && q.slot_sel <= `SLOT_MAX)
		begin
			slot_we = 1'b1;
			slot_wd = '{has_lock: 1'b1, lock: kl_q, set: q.set};
		end
		else if (front_save_in && !kl_q && front_slot_in != 7'h0 && front_slot_in <= `SLOT_MAX)
		begin
			slot_we = 1'b1;
			slot_wa = front_slot_in;
			slot_wd = '{has_lock: 1'b0, lock: 1'b0, set: q.set};
		end

		// loads: pin lines are active low; an unchanged pattern only measures
		if (measure_request_pin_pin && panel_select_lines_in != q.last_sel)
		begin
			load_req  = (~panel_select_lines_in != 7'h0);
			load_slot = ~panel_select_lines_in;
		end
		else if (cmd[`C_LOAD])
			load_req = 1'b1;
		else if (front_load_in && !kl_q)
		begin
			load_req  = 1'b1;
			load_slot = front_slot_in;
		end
		if (measure_request_pin_pin)
			d.last_sel = panel_select_lines_in;
		load_ok = load_req && used_q[load_slot];
		if (load_req && !load_ok)
			d.beep = 1'b1;

		// settings
		nset = q.set;
		if (wr && avs_req_in.address == `A_SET)
			nset = settings_t'(avs_req_in.writedata[15:0]);
		if (load_ok)
		begin
			nset = slot_mem[load_slot].set;
			if (slot_mem[load_slot].has_lock)
				kl_d = slot_mem[load_slot].lock;
		end
		any_rst = cmd[`C_MENU_RST] || cmd[`C_STD_RST] || cmd[`C_SYS_RST];
		if (any_rst)
			nset = settings_t'(`SET_RST);
		d.set = nset;
		if (wr && avs_req_in.address == `A_SLOT)
			d.slot_sel = avs_req_in.writedata[6:0];

		clear = cmd[`C_CLR] || any_rst || (nset.store_en && !q.set.store_en)
			|| nset.range != q.set.range || nset.comp != q.set.comp;

		// self-calibration pacing
		d.cal_tmr = q.cal_tmr + 38'h1;
		if (busy)
			d.cal_left = q.cal_left - 23'h1;
		if (q.set.cal_auto && q.cal_tmr >= CAL_PERIOD_CYC - 38'h1)
		begin
			d.cal_tmr = 38'h0;
			if (!busy)
				d.cal_left = CAL_TIME_CYC;
		end
		if (!q.set.cal_auto && q.cal_q && !cal_line_b_in && !busy)
			d.cal_left = CAL_TIME_CYC;

		// measurement launch, held off while calibrating
		if (measure_request_pin_key || measure_request_pin_pin || measure_request_pin_rmt)
		begin
			d.armed    = 1'b1;
			d.out_pend = q.set.out_en && !q.set.gpib && !measure_request_pin_rmt;
			if (q.set.ext)
				d.meas_pend = 1'b1;
		end
		if (!q.set.ext && !q.inflight)
			d.meas_pend = 1'b1;
		if (!busy && q.meas_pend && !q.inflight)
		begin
			if (q.set.slow && !q.cal_done)
			begin
				d.cal_left = CAL_TIME_CYC;
				d.cal_done = 1'b1;
			end
			else
			begin
				d.meas_start = 1'b1;
				d.inflight   = 1'b1;
				d.meas_pend  = 1'b0;
				d.cal_done   = 1'b0;
			end
		end

		// result taking: one per armed trigger, never while suspended
		if (q.tx_valid && tx_ready_in)
			d.tx_valid = 1'b0;
		if (meas_done_in)
			d.inflight = 1'b0;
		if (meas_done_in && !busy && q.armed)
		begin
			// a trigger in the same cycle keeps its own arm, so it is never lost
			if (!(measure_request_pin_key || measure_request_pin_pin || measure_request_pin_rmt))
			begin
				d.armed    = 1'b0;
				d.out_pend = 1'b0;
			end
			if (q.set.store_en && q.cnt < `REC_CAP && !clear)
			begin
				rec_we  = 1'b1;
				d.cnt   = q.cnt + 9'h1;
				d.blink = 1'b1;
			end
			if (q.out_pend && q.dst == D_IDLE && free)
			begin
				d.tx       = '{is_end: 1'b0, index: 9'h0, rec: meas_rec_in};
				d.tx_valid = 1'b1;
			end
		end
		if (clear)
			d.cnt = 9'h0;

		// dump engine
		case (q.dst)
			D_IDLE:
			begin
				d.idx = 9'h0;
				if (cmd[`C_BULK])
					d.dst = D_BULK;
				else if (cmd[`C_STEP])
					d.dst = D_STEP;
			end
			D_BULK, D_STEP:
			begin
				if (free)
				begin
					d.tx_valid = 1'b1;
					if (q.idx < q.cnt)
					begin
						d.tx  = '{is_end: 1'b0, index: q.idx + 9'h1, rec: rec_mem[q.idx]};
						d.idx = q.idx + 9'h1;
						if (q.dst == D_STEP)
							d.dst = D_WAIT;
					end
					else
					begin
						d.tx  = '{is_end: 1'b1, index: 9'h0, rec: '0};
						d.dst = D_IDLE;
					end
				end
			end
			D_WAIT:
			begin
				if (cmd[`C_NEXT])
					d.dst = D_STEP;
			end
			default:
				d.dst = D_IDLE;
		endcase

		// bus read, one wait state
		d.rd_done = rd && !q.rd_done;
		if (rd && !q.rd_done)
		begin
			case (avs_req_in.address)
				`A_SET:  d.rdata = {16'h0, q.set};
				`A_STAT: d.rdata = {24'h0, q.dst, busy, kl_q, q.armed, q.tx_valid, q.inflight, q.meas_pend};
				`A_CNT:  d.rdata = {23'h0, q.cnt};
				`A_SLOT: d.rdata = {23'h0, used_q[q.slot_sel], 1'b0, q.slot_sel};
				default: d.rdata = 32'h0;
			endcase
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			q          <= '0;
			q.set      <= settings_t'(`SET_RST);
			q.slot_sel <= `SEL_RST;
			q.last_sel <= `SLOT_NONE;
			q.pin_q    <= 1'b1;
			q.cal_q    <= 1'b1;
		end
		else
			q <= d;
	end

	always_ff @(posedge clk_sys_in)
	begin
		kl_q <= kl_d;
		if (rec_we)
			rec_mem[q.cnt] <= meas_rec_in;
		if (slot_we)
		begin
			slot_mem[slot_wa] <= slot_wd;
			used_q[slot_wa]   <= 1'b1;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++)
		begin : g_key
			assign keys_out[gi] = front_keys_in[gi] && !kl_q;
		end
	endgenerate

	assign avs_waitrequest_out = rd && !q.rd_done;
	assign avs_readdata_out    = q.rdata;
	assign meas_start_out      = q.meas_start;
	assign meas_suspend_out    = busy;
	assign front_slot_used_out = used_q[front_slot_in];
	assign tx_out              = q.tx;
	assign tx_valid_out        = q.tx_valid;
	assign settings_out        = q.set;
	assign key_lock_out        = kl_q;
	assign autorange_en_out    = q.set.autorange && !q.set.store_en;
	assign store_lamp_out      = q.set.store_en && !q.blink;
	assign beep_out            = q.beep;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);

	sequence s_waiting;
		q.dst == D_WAIT && !cmd[`C_NEXT];
	endsequence

	sequence s_cal_begin;
		!busy ##1 busy;
	endsequence

	a_count_cap: assert property (q.cnt <= `REC_CAP)
		else $error("record count above capacity");
	a_full_no_store: assert property (q.cnt == `REC_CAP && !clear |=> q.cnt == `REC_CAP)
		else $error("full store changed");
	a_store_appends: assert property (rec_we |=> q.cnt == $past(q.cnt) + 9'h1 && !store_lamp_out)
		else $error("store did not append one record");
	a_enable_clears: assert property ($rose(q.set.store_en) |-> q.cnt == 9'h0)
		else $error("enable did not clear store");
	a_autorange_off: assert property (q.set.store_en |-> !autorange_en_out)
		else $error("auto-range while store enabled");
	a_lock_keys: assert property (kl_q |-> keys_out == 16'h0)
		else $error("key passed during lockout");
	a_step_hold: assert property (s_waiting |=> q.dst == D_WAIT)
		else $error("step dump left wait without next");
	a_cal_length: assert property (s_cal_begin |-> q.cal_left == CAL_TIME_CYC)
		else $error("calibration length wrong");
	a_cal_suspend: assert property (busy |=> !meas_start_out)
		else $error("measurement launched during calibration");
	a_empty_beep: assert property (load_req && !used_q[load_slot] |=> beep_out && settings_out == $past(settings_out))
		else $error("empty slot load not refused");

endmodule

// [meas_engine_model.sv]
// measurement engine stand-in: answers each start taken while idle with one result after a delay
`timescale 1ns/1ps
module meas_engine_model
#(
	parameter int DLY = 6
)
(
	input  wire  logic                  clk_sys_in,
	input  wire  logic                  rst_b_in,
	input  wire  logic                  start_in,
	output logic                        done_out,
	output record_store_pkg::record_t   rec_out
);
	import record_store_pkg::*;
	int cnt;
	int n;
	// ****
	// engine
	// ****
	// outside the done pulse the result lines toggle, so a stale sample never matches
	always @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			cnt <= 0;
			n <= 0;
			done_out <= 1'b0;
			rec_out <= '1;
		end
		else if (cnt == 1)
		begin
			cnt <= 0;
			n <= n + 1;
			done_out <= 1'b1;
			rec_out <= {32'h1000 + 32'(n), 32'h2000 + 32'(n)};
		end
		else
		begin
			done_out <= 1'b0;
			rec_out <= ~rec_out;
			if (cnt > 1)
				cnt <= cnt - 1;
			else if (start_in)
				cnt <= DLY;
		end
	end
endmodule

// [test_measurement_record_store.sv]
// self-checking bench for the measurement record store
`timescale 1ns/1ps
`include "record_store_consts.svh"
module test_measurement_record_store;
	import record_store_pkg::*;
	logic        clk_sys_in = 1'b0;
	logic        rst_b_in = 1'b0;
	avs_req_t    req = '0;
	logic        waitreq;
	logic [31:0] rdata;
	logic        done;
	record_t     rec;
	logic        start;
	logic        front_measure_request_pin = 1'b0;
	logic [15:0] front_keys = 16'hffff;
	logic [15:0] keys;
	logic        slot_used;
	logic        pin_b = 1'b1;
	logic [6:0]  sel_b = 7'h7f;
	logic        cal_b = 1'b1;
	logic        susp;
	localparam int CAL_T = 20;
	tx_t         tx;
	logic        tx_valid;
	logic        tx_ready = 1'b1;
	logic        stall = 1'b0;
	settings_t   set;
	logic        lock;
	logic        auto_en;
	logic        lamp;
	logic        beep;
	logic        cap_en = 1'b0;
	record_t     exp_q[$];
	tx_t         rx_q[$];
	int          err_count = 0;
	int          n_checks = 0;
	int          blinks = 0;
	int          beeps = 0;
	logic [31:0] rd_v;
	int          k;
	int          b;
	int          clr_bits[4] = '{`C_CLR, `C_MENU_RST, `C_STD_RST, `C_SYS_RST};

	always #4 clk_sys_in = ~clk_sys_in;

	// ****
	// observers
	// ****
	// sampled on the falling edge so registered outputs have settled
	always @(negedge clk_sys_in)
	begin
		if (done && cap_en)
			exp_q.push_back(rec);
		if (tx_valid && tx_ready)
			rx_q.push_back(tx);
		if (beep)
			beeps++;
		if (!lamp && set.store_en)
			blinks++;
	end

	always @(posedge clk_sys_in)
		tx_ready <= stall ? ~tx_ready : 1'b1;

	measurement_record_store #(.CAL_PERIOD_CYC(38'd2000), .CAL_TIME_CYC(23'(CAL_T))) measurement_record_store_inst (
		.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .avs_req_in(req), .avs_waitrequest_out(waitreq),
		.avs_readdata_out(rdata), .meas_done_in(done), .meas_rec_in(rec), .meas_start_out(start),
		.meas_suspend_out(susp), .front_measure_request_pin_in(front_measure_request_pin), .front_keys_in(front_keys), .keys_out(keys),
		.front_save_in(1'b0), .front_load_in(1'b0), .front_slot_in(7'h05), .front_slot_used_out(slot_used),
		.measure_request_pin_b_in(pin_b), .panel_select_lines_in(sel_b), .cal_line_b_in(cal_b),
		.tx_out(tx), .tx_valid_out(tx_valid), .tx_ready_in(tx_ready), .settings_out(set),
		.key_lock_out(lock), .autorange_en_out(auto_en), .store_lamp_out(lamp), .beep_out(beep));

	meas_engine_model meas_engine_model_inst (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
		.start_in(start), .done_out(done), .rec_out(rec));

	// ****
	// tasks
	// ****
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic fail();
		$display("[ERR] %0t wait ran out", $time);
		err_count++;
		report_and_stop();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
			err_count++;
		end
	endtask

	// holds the request until waitrequest is seen low, then takes data and releases
	task automatic bus(input logic r, input logic [7:0] a, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge clk_sys_in);
		req <= '{r, !r, a, d};
		@(negedge clk_sys_in);
		while (waitreq !== 1'b0)
		begin
			i++;
			if (i > 50) fail();
			@(negedge clk_sys_in);
		end
		@(posedge clk_sys_in);
		rd_v = rdata;
		req <= '0;
		@(negedge clk_sys_in);
	endtask

	task automatic cmd(input int bit_no);
		bus(1'b0, `A_CMD, 32'h1 << bit_no);
	endtask

	task automatic wait_cnt(input int e);
		int i;
		for (i = 0; i < 100; i++)
		begin
			bus(1'b1, `A_CNT, '0);
			if ((rd_v & 32'h1ff) === 32'(e)) break;
		end
		if (i == 100) fail();
		chk(rd_v & 32'h1ff, 32'(e));
	endtask

	task automatic wait_rx(input int n);
		int i;
		for (i = 0; rx_q.size() < n; i++)
		begin
			if (i > 500) fail();
			@(posedge clk_sys_in);
		end
	endtask

	// polling the status word avoids guessing how long a measurement runs
	task automatic idle();
		int i;
		rd_v = 32'h3;
		for (i = 0; rd_v[1:0] !== 2'b00; i++)
		begin
			if (i > 100) fail();
			bus(1'b1, `A_STAT, '0);
		end
	endtask

	task automatic chk_item(input int i, input logic last);
		chk(32'(rx_q[i].is_end), 32'(last));
		if (!last)
		begin
			chk(32'(rx_q[i].index), 32'(i + 1));
			chk(rx_q[i].rec.res, exp_q[i].res);
			chk(rx_q[i].rec.volt, exp_q[i].volt);
		end
	endtask

	task automatic pin_measure_request_pin();
		@(posedge clk_sys_in);
		pin_b <= 1'b0;
		@(posedge clk_sys_in);
		@(posedge clk_sys_in);
		pin_b <= 1'b1;
	endtask

	// ****
	// main sequence
	// ****
	initial
	begin
		repeat (4) @(posedge clk_sys_in);
		rst_b_in <= 1'b1;
		bus(1'b1, `A_SET, '0);
		chk(rd_v, 32'(`SET_RST));
		bus(1'b1, `A_CNT, '0);
		chk(rd_v, '0);
		bus(1'b1, `A_SLOT, '0);
		chk(rd_v & 32'h7f, 32'(`SEL_RST));
		bus(1'b1, 8'h20, '0);
		chk(rd_v, '0);
		$display("test reset done");
		bus(1'b0, `A_SET, 32'h0042);
		idle();
		bus(1'b0, `A_SET, 32'h0043);
		chk(32'(lamp), 32'h1);
		chk(32'(auto_en), '0);
		cap_en = 1'b1;
		for (k = 1; k <= 3; k++)
		begin
			cmd(`C_TRG);
			wait_cnt(k);
		end
		chk(32'(blinks), 32'd3);
		stall = 1'b1;
		cmd(`C_BULK);
		wait_rx(4);
		for (k = 0; k < 4; k++)
			chk_item(k, k == 3);
		rx_q.delete();
		stall = 1'b0;
		wait_cnt(3);
		cmd(`C_TRG);
		wait_cnt(4);
		$display("test bulk done");
		cmd(`C_STEP);
		wait_rx(1);
		idle();
		chk(32'(rx_q.size()), 32'd1);
		for (k = 2; k <= 5; k++)
		begin
			cmd(`C_NEXT);
			wait_rx(k);
		end
		for (k = 0; k < 5; k++)
			chk_item(k, k == 4);
		$display("test step done");
		foreach (clr_bits[b])
		begin
			cmd(clr_bits[b]);
			wait_cnt(0);
			bus(1'b0, `A_SET, 32'h0043);
			cmd(`C_TRG);
			wait_cnt(1);
		end
		bus(1'b0, `A_SET, 32'h00c3);
		wait_cnt(0);
		for (k = 1; k <= 400; k++)
		begin
			cmd(`C_TRG);
			wait_cnt(k);
		end
		cmd(`C_TRG);
		idle();
		wait_cnt(400);
		$display("test capacity done");
		cmd(`C_CLR);
		wait_cnt(0);
		cmd(`C_LOCK_SET);
		idle();
		chk(32'(keys), '0);
		chk(32'(lock), 32'h1);
		@(posedge clk_sys_in);
		front_measure_request_pin <= 1'b1;
		@(posedge clk_sys_in);
		front_measure_request_pin <= 1'b0;
		wait_cnt(1);
		cmd(`C_LOCK_CLR);
		idle();
		chk(32'(keys), 32'hffff);
		$display("test lockout done");
		bus(1'b0, `A_SLOT, 32'h5);
		cmd(`C_LOAD);
		idle();
		chk(32'(beeps), 32'h1);
		bus(1'b1, `A_SET, '0);
		chk(rd_v & 32'hffff, 32'h00c3);
		cmd(`C_SAVE);
		bus(1'b1, `A_SLOT, '0);
		chk(32'(rd_v[8]), 32'h1);
		chk(32'(slot_used), 32'h1);
		bus(1'b0, `A_SET, 32'h0083);
		cmd(`C_LOAD);
		bus(1'b1, `A_SET, '0);
		chk(rd_v & 32'hffff, 32'h00c3);
		$display("test slots done");
		rx_q.delete();
		bus(1'b0, `A_SET, 32'h00c7);
		pin_measure_request_pin();
		wait_rx(1);
		chk(32'(rx_q[0].index), '0);
		wait_cnt(2);
		bus(1'b0, `A_SET, 32'h00e7);
		pin_measure_request_pin();
		wait_cnt(3);
		idle();
		chk(32'(rx_q.size()), 32'd1);
		$display("test output done");
		sel_b <= ~7'h05;
		pin_measure_request_pin();
		wait_cnt(4);
		bus(1'b1, `A_SET, '0);
		chk(rd_v & 32'hffff, 32'h00c3);
		bus(1'b0, `A_SET, 32'h00e7);
		pin_measure_request_pin();
		wait_cnt(5);
		bus(1'b1, `A_SET, '0);
		chk(rd_v & 32'hffff, 32'h00e7);
		@(posedge clk_sys_in);
		cal_b <= 1'b0;
		@(posedge clk_sys_in);
		cal_b <= 1'b1;
		k = 0;
		for (b = 0; b < 60; b++)
		begin
			@(negedge clk_sys_in);
			if (susp === 1'b1) k++;
		end
		chk(32'(k), 32'(CAL_T));
		$display("test panel done");
		report_and_stop();
	end
endmodule
